//--- rtl/fpo_presence.sv
// Finger presence detection, motion cutoff and axis orientation.
// Assumes frame results and register requests arrive on clk_sys_in.
`timescale 1ns/100ps
// Functional notes
// RL1: With cutoff enabled, motion is suppressed while shutter is below threshold times 256.
// RL2: Arrival and departure each need a programmable count of qualifying frames.
// RL3: Reflectivity level is compared with the 8-bit presence threshold.
// RL4: Axis exchange bit 7 swaps horizontal and vertical counts.
// RL5: Vertical negate bit 6 inverts the reported vertical count.
// RL6: Horizontal negate bit 5 inverts the reported horizontal count.
// RL7: Quality enable bit 0 at 0x61 adds quality threshold comparison.
// RL8: Reflectivity level is readable, larger means more reflective.
// RL9: Finger present flag reads in status bit 0.
// RL10: Level hysteresis is eight times status bits 7:4.
// RL11: Quality hysteresis is four times status bits 3:1.
// RL12: Flag reads 1 with a finger, 0 without.
// RL13: Status writes change only hysteresis fields, never the flag.
// RL14: Exchange happens first, then negation per output axis.
module fpo_presence (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // Register port
    input wire fpo_pkg::fpo_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    // Frame engine
    input wire fpo_pkg::fpo_frame_t frame_in,
    // Reported motion and presence
    output logic [7:0] delta_x_out,
    output logic [7:0] delta_y_out,
    output logic motion_valid_out,
    output logic finger_present_out
);
    import fpo_pkg::*;

    fpo_state_t st;
    fpo_state_t next_st;
    logic [15:0] cut_level;
    logic cut_active;
    logic sq_en;
    logic [7:0] lvl_low;
    logic [7:0] sq_low;
    logic [7:0] lvl_span;
    logic [7:0] sq_span;
    logic on_cond;
    logic off_cond;
    logic [1:0] need;
    logic [7:0] sw_x;
    logic [7:0] sw_y;

    always_comb
    begin
        cut_level = {4'h0, st.pres_ctrl[FPO_CUT_HI:FPO_CUT_LO], FPO_CUT_STEP_ZERO}; // RL1
        cut_active = st.cut_ctrl[FPO_BIT_CUT_EN] && (frame_in.shutter < cut_level); // RL1
        sq_en = st.engine[FPO_BIT_SQ_EN]; // RL7
        lvl_span = {1'b0, st.lvl_hyst, FPO_LHYST_ZERO}; // RL10
        sq_span = {3'h0, st.sq_hyst, FPO_QHYST_ZERO}; // RL11
        lvl_low = (st.lvl_thr > lvl_span) ? st.lvl_thr - lvl_span : FPO_RST_REG;
        sq_low = (st.sq_thr > sq_span) ? st.sq_thr - sq_span : FPO_RST_REG;
        on_cond = (frame_in.level >= st.lvl_thr) && (!sq_en || frame_in.squal >= st.sq_thr); // RL3
        off_cond = (frame_in.level < lvl_low) || (sq_en && frame_in.squal < sq_low); // RL7
        need = (st.pres == FPO_ABSENT) ? st.pres_ctrl[FPO_ON_HI:FPO_ON_LO]
                                      : st.pres_ctrl[FPO_OFF_HI:FPO_OFF_LO];
        sw_x = st.orient[FPO_BIT_SWAP] ? frame_in.dy : frame_in.dx; // RL4
        sw_y = st.orient[FPO_BIT_SWAP] ? frame_in.dx : frame_in.dy; // RL4
    end

    always_comb
    begin
        next_st = st;
        next_st.mot_valid = 1'b0;
        if (frame_in.valid)
        begin
            next_st.lvl_val = frame_in.level; // RL8
            case (st.pres)
                FPO_ABSENT:
                begin
                    if (!on_cond)
                        next_st.cnt = FPO_RST_CNT;
                    else if (st.cnt >= need)
                    begin
                        next_st.pres = FPO_PRESENT; // RL2
                        next_st.cnt = FPO_RST_CNT;
                    end
                    else
                        next_st.cnt = st.cnt + 2'h1;
                end
                FPO_PRESENT:
                begin
                    if (!off_cond)
                        next_st.cnt = FPO_RST_CNT;
                    else if (st.cnt >= need)
                    begin
                        next_st.pres = FPO_ABSENT; // RL2
                        next_st.cnt = FPO_RST_CNT;
                    end
                    else
                        next_st.cnt = st.cnt + 2'h1;
                end
                default:
                begin
                    next_st.pres = FPO_ABSENT;
                    next_st.cnt = FPO_RST_CNT;
                end
            endcase
            if (cut_active)
            begin
                next_st.dx = FPO_RST_REG; // RL1
                next_st.dy = FPO_RST_REG; // RL1
            end
            else
            begin
                next_st.dx = st.orient[FPO_BIT_XNEG] ? 8'h00 - sw_x : sw_x; // RL6 RL14
                next_st.dy = st.orient[FPO_BIT_YNEG] ? 8'h00 - sw_y : sw_y; // RL5 RL14
                next_st.mot_valid = 1'b1;
            end
        end
        if (reg_req_in.wr)
        begin
            case (reg_req_in.addr)
                FPO_ADDR_CUTOFF_EN: next_st.cut_ctrl = reg_req_in.wdata;
                FPO_ADDR_ENGINE: next_st.engine = reg_req_in.wdata;
                FPO_ADDR_PRES_CTRL: next_st.pres_ctrl = reg_req_in.wdata;
                FPO_ADDR_LVL_THR: next_st.lvl_thr = reg_req_in.wdata;
                FPO_ADDR_ORIENT: next_st.orient = reg_req_in.wdata;
                FPO_ADDR_SQ_THR: next_st.sq_thr = reg_req_in.wdata;
                FPO_ADDR_STATUS:
                begin
                    next_st.lvl_hyst = reg_req_in.wdata[FPO_LHYST_HI:FPO_LHYST_LO]; // RL13
                    next_st.sq_hyst = reg_req_in.wdata[FPO_QHYST_HI:FPO_QHYST_LO]; // RL13
                end
                default: next_st.rdata = st.rdata;
            endcase
        end
        if (reg_req_in.rd)
        begin
            case (reg_req_in.addr)
                FPO_ADDR_CUTOFF_EN: next_st.rdata = st.cut_ctrl;
                FPO_ADDR_ENGINE: next_st.rdata = st.engine;
                FPO_ADDR_PRES_CTRL: next_st.rdata = st.pres_ctrl;
                FPO_ADDR_LVL_THR: next_st.rdata = st.lvl_thr;
                FPO_ADDR_ORIENT: next_st.rdata = {st.orient[FPO_BIT_SWAP:FPO_BIT_XNEG], 5'h00};
                FPO_ADDR_SQ_THR: next_st.rdata = st.sq_thr;
                FPO_ADDR_LVL_VAL: next_st.rdata = st.lvl_val; // RL8
                FPO_ADDR_STATUS:
                    next_st.rdata = {st.lvl_hyst, st.sq_hyst, st.pres == FPO_PRESENT}; // RL9 RL12
                default: next_st.rdata = FPO_RST_REG;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st.cut_ctrl <= FPO_RST_REG;
            st.engine <= FPO_RST_REG;
            st.pres_ctrl <= FPO_RST_REG;
            st.lvl_thr <= FPO_RST_REG;
            st.orient <= FPO_RST_REG;
            st.sq_thr <= FPO_RST_REG;
            st.lvl_val <= FPO_RST_REG;
            st.lvl_hyst <= FPO_RST_LVL_HYST;
            st.sq_hyst <= FPO_RST_SQ_HYST;
            st.pres <= FPO_ABSENT;
            st.cnt <= FPO_RST_CNT;
            st.dx <= FPO_RST_REG;
            st.dy <= FPO_RST_REG;
            st.mot_valid <= 1'b0;
            st.rdata <= FPO_RST_REG;
        end
        else
            st <= next_st;
    end

    assign reg_rdata_out = st.rdata;
    assign delta_x_out = st.dx;
    assign delta_y_out = st.dy;
    assign motion_valid_out = st.mot_valid;
    assign finger_present_out = (st.pres == FPO_PRESENT);

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);

    chk_cutoff_zero: assert property (frame_in.valid && cut_active // RL1
        |=> delta_x_out == 8'h00 && delta_y_out == 8'h00 && !motion_valid_out)
        else $error("motion not suppressed under cutoff");
    chk_arrival_qualified: assert property ($rose(finger_present_out) // RL2
        |-> $past(frame_in.valid && on_cond && st.cnt >= st.pres_ctrl[FPO_ON_HI:FPO_ON_LO]))
        else $error("presence declared without qualified count");
    chk_level_compare: assert property (frame_in.valid && frame_in.level < st.lvl_thr // RL3
        && !finger_present_out |=> !finger_present_out)
        else $error("presence declared below level threshold");
    chk_swap_plain: assert property (frame_in.valid && !cut_active && st.orient[7:5] == 3'b100 // RL4
        |=> delta_x_out == $past(frame_in.dy) && delta_y_out == $past(frame_in.dx))
        else $error("axis exchange wrong");
    chk_y_negate: assert property (frame_in.valid && !cut_active && st.orient[7:5] == 3'b010 // RL5
        |=> delta_y_out == 8'h00 - $past(frame_in.dy) && delta_x_out == $past(frame_in.dx))
        else $error("vertical negate wrong");
    chk_x_negate: assert property (frame_in.valid && !cut_active && st.orient[7:5] == 3'b001 // RL6
        |=> delta_x_out == 8'h00 - $past(frame_in.dx) && delta_y_out == $past(frame_in.dy))
        else $error("horizontal negate wrong");
    chk_swap_negate: assert property (frame_in.valid && !cut_active && st.orient[7:5] == 3'b111 // RL14
        |=> delta_x_out == 8'h00 - $past(frame_in.dy) && delta_y_out == 8'h00 - $past(frame_in.dx))
        else $error("exchange then negate wrong");
    chk_quality_gate: assert property (frame_in.valid && sq_en && frame_in.squal < st.sq_thr // RL7
        && !finger_present_out |=> !finger_present_out)
        else $error("quality gate ignored");
    chk_value_read: assert property (reg_req_in.rd && reg_req_in.addr == FPO_ADDR_LVL_VAL // RL8
        |=> reg_rdata_out == $past(st.lvl_val))
        else $error("level read wrong");
    chk_status_read: assert property (reg_req_in.rd && reg_req_in.addr == FPO_ADDR_STATUS // RL9
        |=> reg_rdata_out[FPO_BIT_PRESENT] == $past(finger_present_out))
        else $error("present flag read wrong");
    chk_status_write: assert property (reg_req_in.wr && reg_req_in.addr == FPO_ADDR_STATUS // RL13
        && !frame_in.valid |=> finger_present_out == $past(finger_present_out))
        else $error("status write changed flag");
    chk_hold_inband: assert property (frame_in.valid && finger_present_out // RL10
        && frame_in.level >= lvl_low && !sq_en |=> finger_present_out)
        else $error("departure inside level band");
endmodule

//--- shared/fpo_pkg.sv
// Package for the finger presence and orientation block.
// Assumes a register port on the sensor clock and a frame engine on the same clock.
package fpo_pkg;
    // Register offsets
    localparam logic [7:0] FPO_ADDR_CUTOFF_EN = 8'h60;
    localparam logic [7:0] FPO_ADDR_ENGINE = 8'h61;
    localparam logic [7:0] FPO_ADDR_PRES_CTRL = 8'h75;
    localparam logic [7:0] FPO_ADDR_LVL_THR = 8'h76;
    localparam logic [7:0] FPO_ADDR_ORIENT = 8'h77;
    localparam logic [7:0] FPO_ADDR_SQ_THR = 8'h78;
    localparam logic [7:0] FPO_ADDR_LVL_VAL = 8'h79;
    localparam logic [7:0] FPO_ADDR_STATUS = 8'h7a;
    // Reset values
    localparam logic [7:0] FPO_RST_REG = 8'h00;
    localparam logic [3:0] FPO_RST_LVL_HYST = 4'h0;
    localparam logic [2:0] FPO_RST_SQ_HYST = 3'h0;
    localparam logic [1:0] FPO_RST_CNT = 2'h0;
    // Field positions
    localparam int FPO_BIT_SWAP = 7;
    localparam int FPO_BIT_YNEG = 6;
    localparam int FPO_BIT_XNEG = 5;
    localparam int FPO_BIT_SQ_EN = 0;
    localparam int FPO_BIT_CUT_EN = 0;
    localparam int FPO_CUT_HI = 7;
    localparam int FPO_CUT_LO = 4;
    localparam int FPO_ON_HI = 3;
    localparam int FPO_ON_LO = 2;
    localparam int FPO_OFF_HI = 1;
    localparam int FPO_OFF_LO = 0;
    localparam int FPO_LHYST_HI = 7;
    localparam int FPO_LHYST_LO = 4;
    localparam int FPO_QHYST_HI = 3;
    localparam int FPO_QHYST_LO = 1;
    localparam int FPO_BIT_PRESENT = 0;
    // Scale factors as zero fill widths
    localparam logic [7:0] FPO_CUT_STEP_ZERO = 8'h00;
    localparam logic [2:0] FPO_LHYST_ZERO = 3'h0;
    localparam logic [1:0] FPO_QHYST_ZERO = 2'h0;

    typedef enum logic {FPO_ABSENT, FPO_PRESENT} fpo_pres_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fpo_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] level;
        logic [7:0] squal;
        logic [15:0] shutter;
        logic [7:0] dx;
        logic [7:0] dy;
    } fpo_frame_t;

    typedef struct packed {
        logic [7:0] cut_ctrl;
        logic [7:0] engine;
        logic [7:0] pres_ctrl;
        logic [7:0] lvl_thr;
        logic [7:0] orient;
        logic [7:0] sq_thr;
        logic [7:0] lvl_val;
        logic [3:0] lvl_hyst;
        logic [2:0] sq_hyst;
        fpo_pres_t pres;
        logic [1:0] cnt;
        logic [7:0] dx;
        logic [7:0] dy;
        logic mot_valid;
        logic [7:0] rdata;
    } fpo_state_t;
endpackage

//--- tb/fpo_host_model.sv
// Host model driving register reads and writes into the presence block.
// Assumes the bench calls its task and compares read data itself.
`timescale 1ns/100ps
module fpo_host_model (
    // Clock
    input wire logic clk_sys_in,
    // Register requests
    output fpo_pkg::fpo_reg_req_t req_out
);
    import fpo_pkg::*;

    initial req_out = '0;

    // One request pulse, then address and data left inverted
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        req_out = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(negedge clk_sys_in);
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

//--- tb/tb_top.sv
// Bench for the presence block: host model on registers, frames from here.
// Assumes answers come one cycle after each request or frame.
`timescale 1ns/100ps
module tb_top;
    import fpo_pkg::*;
    logic clk_sys_in;
    logic arst_n_in;
    fpo_reg_req_t req;
    fpo_frame_t fr;
    logic [7:0] rdat;
    logic [7:0] dxo;
    logic [7:0] dyo;
    logic mvo;
    logic preso;
    int err_count = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'd2620;
    logic [7:0] rd_q[$];
    logic [17:0] fr_q[$];
    logic [17:0] e;
    logic rd_d = 1'b0;
    logic fv_d = 1'b0;
    logic cut_en = 1'b0;
    logic sq_en = 1'b0;
    logic [7:0] pctl = 8'h00;
    logic [7:0] lthr = 8'h00;
    logic [7:0] ori = 8'h00;
    logic [7:0] sthr = 8'h00;
    logic [7:0] lv = 8'h00;
    logic [6:0] hy = 7'h00;
    logic m_pres = 1'b0;
    logic [1:0] m_cnt = 2'h0;
    logic [7:0] adrs [9] = '{8'h60, 8'h61, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h10};

    fpo_presence dut_u (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_req_in(req),
        .reg_rdata_out(rdat), .frame_in(fr), .delta_x_out(dxo), .delta_y_out(dyo),
        .motion_valid_out(mvo), .finger_present_out(preso));
    fpo_host_model host_u (.clk_sys_in(clk_sys_in), .req_out(req));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string w, input logic [7:0] x, input logic [7:0] g);
        n_tests++;
        if (g !== x)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", w, x, g);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        case (a)
            FPO_ADDR_CUTOFF_EN: cut_en = d[0];
            FPO_ADDR_ENGINE: sq_en = d[0];
            FPO_ADDR_PRES_CTRL: pctl = d;
            FPO_ADDR_LVL_THR: lthr = d;
            FPO_ADDR_ORIENT: ori = d;
            FPO_ADDR_SQ_THR: sthr = d;
            FPO_ADDR_STATUS: hy = d[7:1];
            default: ;
        endcase
        host_u.access(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        rd_q.push_back(x);
        host_u.access(1'b0, a, 8'h00);
    endtask

    // One frame with random motion, level and quality near the thresholds
    task automatic frm(input logic [15:0] sh);
        logic [31:0] r;
        logic [7:0] ox;
        logic [7:0] oy;
        logic [7:0] sq;
        logic cut;
        logic hit;
        r = xs();
        ox = ori[7] ? r[15:8] : r[7:0];
        oy = ori[7] ? r[7:0] : r[15:8];
        if (ori[5])
            ox = -ox;
        if (ori[6])
            oy = -oy;
        cut = cut_en && sh < {4'h0, pctl[7:4], 8'h00};
        lv = 8'h60 + r[21:16];
        sq = 8'h20 + r[29:24];
        if (m_pres)
            hit = int'(lv) < int'(lthr) - 8 * int'(hy[6:3])
                || (sq_en && int'(sq) < int'(sthr) - 4 * int'(hy[2:0]));
        else
            hit = lv >= lthr && (!sq_en || sq >= sthr);
        if (!hit)
            m_cnt = 2'h0;
        else if (m_cnt >= (m_pres ? pctl[1:0] : pctl[3:2]))
        begin
            m_pres = !m_pres;
            m_cnt = 2'h0;
        end
        else
            m_cnt = m_cnt + 2'h1;
        fr_q.push_back({!cut, m_pres, cut ? 16'h0000 : {ox, oy}});
        @(negedge clk_sys_in);
        fr = '{1'b1, lv, sq, sh, r[7:0], r[15:8]};
        @(negedge clk_sys_in);
        fr.valid = 1'b0;
    endtask

    // Result watcher
    always @(posedge clk_sys_in)
    begin
        if (rd_d)
            chk("rdata", rd_q.pop_front(), rdat);
        if (fv_d)
        begin
            e = fr_q.pop_front();
            chk("motion_valid", {7'h0, e[17]}, {7'h0, mvo});
            chk("present", {7'h0, e[16]}, {7'h0, preso});
            chk("delta_x", e[15:8], dxo);
            chk("delta_y", e[7:0], dyo);
        end
        rd_d = req.rd;
        fv_d = fr.valid;
    end

    initial
    begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    initial
    begin
        repeat (2000) @(posedge clk_sys_in);
        err_count++;
        give_verdict();
    end

    initial
    begin
        arst_n_in = 1'b0;
        fr = '0;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        foreach (adrs[i])
            rd(adrs[i], 8'h00);
        wr(8'h77, 8'hff);
        rd(8'h77, 8'he0);
        wr(8'h79, 8'h55);
        rd(8'h79, 8'h00);
        wr(8'h7a, 8'hff);
        rd(8'h7a, 8'hfe);
        wr(8'h7a, 8'h00);
        for (int o = 0; o < 8; o++)
        begin
            wr(8'h77, {o[2:0], 5'h00});
            repeat (3) frm(16'hffff);
        end
        wr(8'h76, 8'h80);
        wr(8'h75, 8'h09);
        repeat (40) frm(16'hffff);
        rd(8'h7a, {hy, m_pres});
        rd(8'h79, lv);
        wr(8'h61, 8'h01);
        wr(8'h78, 8'h40);
        wr(8'h7a, 8'h27);
        repeat (40) frm(16'hffff);
        rd(8'h7a, {hy, m_pres});
        wr(8'h60, 8'h01);
        wr(8'h75, 8'h39);
        frm(16'h02ff);
        frm(16'h0300);
        repeat (10) frm({5'h00, seed[10:0]});
        repeat (3) @(posedge clk_sys_in);
        give_verdict();
    end
endmodule
